// ### hw/cssc_defs.svh
// Offsets, field positions, reset values and cycle counts of the clock
// source and start-up control block. Assumes byte addressing on AHB-Lite.
`ifndef CSSC_DEFS_SVH
`define CSSC_DEFS_SVH

`define CSSC_OFS_FUSE 4'h0
`define CSSC_OFS_CTRL 4'h4
`define CSSC_OFS_STAT 4'h8

`define CSSC_FUSE_RST 7'h61
`define CSSC_FUSE_SEL_LSB 0
`define CSSC_FUSE_SUT_LSB 4
`define CSSC_FUSE_OPT_BIT 6

`define CSSC_CTRL_MODE_LSB 0
`define CSSC_CTRL_GO_BIT 3

`define CSSC_STAT_STATE_LSB 0
`define CSSC_STAT_KIND_LSB 3
`define CSSC_STAT_RSV_BIT 6
`define CSSC_STAT_DOM_LSB 7
`define CSSC_STAT_RANGE_LSB 12

`define CSSC_SEL_LFXTAL 4'h9
`define CSSC_SEL_XTAL_MIN 4'hA
`define CSSC_SEL_ERC_MIN 4'h5
`define CSSC_SEL_EXTCLK 4'h0

`define CSSC_CK_6 16'h0006
`define CSSC_CK_18 16'h0012
`define CSSC_CK_258 16'h0102
`define CSSC_CK_1K 16'h0400
`define CSSC_CK_16K 16384
`define CSSC_CK_32K 32768
`define CSSC_WDT_4K 4096
`define CSSC_WDT_64K 65536

`endif

// ### hw/cssc_pkg.sv
// Types shared by the clock source and start-up control block.
// Assumes cssc_defs.svh supplies all numeric constants.
package cssc_pkg;
   typedef enum logic [2:0] {ST_RST_EXT, ST_START, ST_RUN, ST_SLEEP, ST_WAKE} cssc_state_t;
   typedef enum logic [2:0] {SM_IDLE, SM_ADC_NR, SM_PSAVE, SM_PDOWN} cssc_mode_t;
   typedef enum logic [2:0] {SK_EXTCLK, SK_IRC, SK_ERC, SK_LFXTAL, SK_XTAL} cssc_kind_t;
   typedef enum logic [2:0] {CC_6, CC_18, CC_258, CC_1K, CC_16K, CC_32K} cssc_cnt_t;
   typedef enum logic [1:0] {EX_NONE, EX_SHORT, EX_LONG} cssc_ext_t;
   typedef enum logic [1:0] {RG_LOW, RG_MID, RG_HIGH, RG_WIDE} cssc_range_t;
   typedef struct packed
   {
      logic core;
      logic flash;
      logic io;
      logic asy;
      logic adc;
   } cssc_dom_t;
endpackage

// ### hw/cssc_top.sv
// Clock source decode, start-up timing and domain clock gating.
// Assumes src_tick_i and wdt_tick_i are one-cycle pulses synchronous to mclk_i.
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "cssc_defs.svh"

module cssc_top
   import cssc_pkg::*;
#(
   parameter int WDT_SHORT = `CSSC_WDT_4K,
   parameter int WDT_LONG = `CSSC_WDT_64K,
   parameter int SRC_16K = `CSSC_CK_16K,
   parameter int SRC_32K = `CSSC_CK_32K
)
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic src_tick_i,
   input wire logic wdt_tick_i,
   input wire logic wake_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic core_clk_en_o,
   output logic flash_clk_en_o,
   output logic io_clk_en_o,
   output logic asy_clk_en_o,
   output logic adc_clk_en_o,
   output logic async_detect_o,
   output logic [2:0] src_kind_o,
   output logic [1:0] osc_range_o
);

   cssc_state_t state_reg, state_next;
   cssc_dom_t dom_reg, dom_next;
   logic [6:0] fuse_reg;
   logic [2:0] mode_reg;
   logic [15:0] src_cnt_reg;
   logic [16:0] wdt_cnt_reg;
   logic [31:0] hrdata_reg;
   logic wr_pend_reg;
   logic [3:0] wr_ofs_reg;
   logic async_reg;
   logic [2:0] kind_reg;
   logic [1:0] range_reg;

   // Fuse fields
   wire [3:0] sel = fuse_reg[`CSSC_FUSE_SEL_LSB +: 4];
   wire [1:0] startup_time_fuses = fuse_reg[`CSSC_FUSE_SUT_LSB +: 2];
   wire opt = fuse_reg[`CSSC_FUSE_OPT_BIT];

   // Source kind; fuse zero means programmed
   cssc_kind_t kind;
   assign kind = (sel >= `CSSC_SEL_XTAL_MIN) ? SK_XTAL :
                 (sel == `CSSC_SEL_LFXTAL) ? SK_LFXTAL :
                 (sel >= `CSSC_SEL_ERC_MIN) ? SK_ERC :
                 (sel == `CSSC_SEL_EXTCLK) ? SK_EXTCLK : SK_IRC;

   // Amplifier mode: programmed option fuse gives the wide rail-to-rail mode
   cssc_range_t range;
   assign range = !opt ? RG_WIDE :
                  (sel[3:1] == 3'b101) ? RG_LOW :
                  (sel[3:1] == 3'b110) ? RG_MID : RG_HIGH;

   // Start-up count and reset extension per source and start-up fuses
   cssc_cnt_t cc;
   cssc_ext_t ex;
   logic rsv;
   always_comb
   begin
      cc = CC_6;
      ex = EX_LONG;
      rsv = 1'b0;
      case (kind)
         SK_XTAL:
         begin
            case ({sel[0], startup_time_fuses})
               3'b000: begin cc = CC_258; ex = EX_SHORT; end
               3'b001: begin cc = CC_258; ex = EX_LONG; end
               3'b010: begin cc = CC_1K; ex = EX_NONE; end
               3'b011: begin cc = CC_1K; ex = EX_SHORT; end
               3'b100: begin cc = CC_1K; ex = EX_LONG; end
               3'b101: begin cc = CC_16K; ex = EX_NONE; end
               3'b110: begin cc = CC_16K; ex = EX_SHORT; end
               default: begin cc = CC_16K; ex = EX_LONG; end
            endcase
         end
         SK_LFXTAL:
         begin
            case (startup_time_fuses)
               2'b00: begin cc = CC_1K; ex = EX_SHORT; end
               2'b01: begin cc = CC_1K; ex = EX_LONG; end
               2'b10: begin cc = CC_32K; ex = EX_LONG; end
               // Reserved: fall back to the safest, longest delay
               default: begin cc = CC_32K; ex = EX_LONG; rsv = 1'b1; end
            endcase
         end
         SK_ERC:
         begin
            cc = (startup_time_fuses == 2'b11) ? CC_6 : CC_18;
            ex = (startup_time_fuses == 2'b00) ? EX_NONE : (startup_time_fuses == 2'b10) ? EX_LONG : EX_SHORT;
         end
         default:
         begin
            cc = CC_6;
            ex = (startup_time_fuses == 2'b00) ? EX_NONE : (startup_time_fuses == 2'b01) ? EX_SHORT : EX_LONG;
            rsv = (startup_time_fuses == 2'b11);
         end
      endcase
   end

   wire [15:0] src_tgt = (cc == CC_18) ? `CSSC_CK_18 :
                         (cc == CC_258) ? `CSSC_CK_258 :
                         (cc == CC_1K) ? `CSSC_CK_1K :
                         (cc == CC_16K) ? SRC_16K[15:0] :
                         (cc == CC_32K) ? SRC_32K[15:0] : `CSSC_CK_6;
   wire [16:0] wdt_tgt = (ex == EX_LONG) ? WDT_LONG[16:0] : WDT_SHORT[16:0];
   wire src_done = src_tick_i && (src_cnt_reg == src_tgt - 16'h0001);
   wire wdt_done = wdt_tick_i && (wdt_cnt_reg == wdt_tgt - 17'h00001);

   // Bus decode
   wire addr_ok = hsel_i && hready_i && htrans_i[1];
   wire [3:0] ofs = haddr_i[3:0];
   wire wr_fuse = wr_pend_reg && (wr_ofs_reg == `CSSC_OFS_FUSE);
   wire wr_ctrl = wr_pend_reg && (wr_ofs_reg == `CSSC_OFS_CTRL);
   wire sleep_go = wr_ctrl && hwdata_i[`CSSC_CTRL_GO_BIT] && (state_reg == ST_RUN);
   // Mode being written now, so the first sleep cycle already gates by it
   wire mode_wr = wr_ctrl && state_reg != ST_SLEEP && state_reg != ST_WAKE;
   wire [2:0] mode_next = mode_wr ? hwdata_i[`CSSC_CTRL_MODE_LSB +: 3] : mode_reg;
   wire [31:0] stat_word = {18'h0, range_reg, dom_reg, rsv, kind_reg, state_reg};
   wire [31:0] rd_mux = (ofs == `CSSC_OFS_FUSE) ? {25'h0, fuse_reg} :
                        (ofs == `CSSC_OFS_CTRL) ? {29'h0, mode_reg} :
                        (ofs == `CSSC_OFS_STAT) ? stat_word : 32'h0;

   // Sequencing: reset extension, then source start-up count, then run
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_RST_EXT:
            if (ex == EX_NONE || wdt_done)
               state_next = ST_START;
         ST_START:
            if (src_done)
               state_next = ST_RUN;
         ST_RUN:
            if (sleep_go)
               state_next = ST_SLEEP;
         // Idle and noise reduction kept the source running, so no count
         ST_SLEEP:
            if (wake_i)
               state_next = (mode_reg == SM_PDOWN || mode_reg == SM_PSAVE) ? ST_WAKE : ST_RUN;
         ST_WAKE:
            if (src_done)
               state_next = ST_RUN;
         default:
            state_next = ST_RST_EXT;
      endcase
   end

   // Domain gating by state and sleep mode
   wire run = (state_next == ST_RUN);
   wire slp = (state_next == ST_SLEEP) || (state_next == ST_WAKE);
   always_comb
   begin
      dom_next.core = run;
      dom_next.flash = run;
      dom_next.io = run || (slp && mode_next == SM_IDLE);
      dom_next.asy = run || (slp && mode_next != SM_PDOWN);
      dom_next.adc = run || (slp && (mode_next == SM_IDLE || mode_next == SM_ADC_NR));
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= ST_RST_EXT;
         dom_reg <= '0;
         src_cnt_reg <= 16'h0000;
         wdt_cnt_reg <= 17'h00000;
      end
      else
      begin
         state_reg <= state_next;
         dom_reg <= dom_next;
         // Counters restart whenever the state moves on
         src_cnt_reg <= (state_next != state_reg) ? 16'h0000 :
                        (src_tick_i ? src_cnt_reg + 16'h0001 : src_cnt_reg);
         wdt_cnt_reg <= (state_next != state_reg) ? 17'h00000 :
                        (wdt_tick_i ? wdt_cnt_reg + 17'h00001 : wdt_cnt_reg);
      end
   end

   // Peripheral clock stopped: hand detection to asynchronous logic
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         async_reg <= 1'b1;
      else
         async_reg <= !dom_next.io;
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         kind_reg <= 3'h0;
         range_reg <= 2'h0;
      end
      else
      begin
         kind_reg <= kind;
         range_reg <= range;
      end
   end

   // Fuse image; new values take effect in the source decode from the next cycle, with no new start-up
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         fuse_reg <= `CSSC_FUSE_RST;
      else if (wr_fuse)
         fuse_reg <= hwdata_i[6:0];
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         mode_reg <= SM_IDLE;
      else if (mode_wr)
         mode_reg <= mode_next;
   end

   // Zero-wait slave: read data registered in the address phase
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_pend_reg <= 1'b0;
         wr_ofs_reg <= 4'h0;
         hrdata_reg <= 32'h0;
      end
      else
      begin
         wr_pend_reg <= addr_ok && hwrite_i;
         wr_ofs_reg <= ofs;
         hrdata_reg <= (addr_ok && !hwrite_i) ? rd_mux : 32'h0;
      end
   end

   assign hrdata_o = hrdata_reg;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign core_clk_en_o = dom_reg.core;
   assign flash_clk_en_o = dom_reg.flash;
   assign io_clk_en_o = dom_reg.io;
   assign asy_clk_en_o = dom_reg.asy;
   assign adc_clk_en_o = dom_reg.adc;
   assign async_detect_o = async_reg;
   assign src_kind_o = kind_reg;
   assign osc_range_o = range_reg;

   // Checks
   sequence wake_count_s;
      state_reg == ST_WAKE && src_done;
   endsequence

   sequence ext_done_s;
      state_reg == ST_RST_EXT && wdt_done;
   endsequence

   flash_follows_core_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      flash_clk_en_o == core_clk_en_o)
      else $error("flash clock enable differs from core");

   core_after_start_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      core_clk_en_o |-> state_reg == ST_RUN)
      else $error("core clock on outside run");

   ext_then_start_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ext_done_s |=> state_reg == ST_START && !core_clk_en_o)
      else $error("reset extension end mishandled");

   wake_count_end_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      wake_count_s |=> core_clk_en_o && state_reg == ST_RUN)
      else $error("wake count end did not start core");

   wake_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      state_reg == ST_WAKE && !src_done |=> !core_clk_en_o)
      else $error("core clock on before wake count ends");

   async_io_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      async_detect_o == !io_clk_en_o)
      else $error("async detect not opposite peripheral clock");

   asy_psave_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      state_reg == ST_SLEEP && mode_reg == SM_PSAVE |-> asy_clk_en_o && !io_clk_en_o)
      else $error("async timer clock stopped in power-save");

   adc_quiet_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      state_reg == ST_SLEEP && mode_reg == SM_ADC_NR |-> adc_clk_en_o && !core_clk_en_o)
      else $error("converter domain gating wrong");

   pdown_off_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      state_reg == ST_SLEEP && mode_reg == SM_PDOWN |-> dom_reg == '0)
      else $error("domain clock running in power-down");

   lf_select_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      $past(sel) == `CSSC_SEL_LFXTAL && $past(wr_fuse) == 1'b0 |-> src_kind_o == SK_LFXTAL)
      else $error("low-frequency source not decoded");

   xtal_group_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      kind == SK_XTAL |-> ((ex == EX_NONE) == ({sel[0], startup_time_fuses} == 3'b010 || {sel[0], startup_time_fuses} == 3'b101))
         && ((src_tgt == `CSSC_CK_258) == ({sel[0], startup_time_fuses[1]} == 2'b00)))
      else $error("crystal start-up decode wrong");

   lf_long_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      kind == SK_LFXTAL && startup_time_fuses == 2'b10 |-> ex == EX_LONG && src_tgt == SRC_32K[15:0])
      else $error("low-frequency long start-up wrong");

   wide_range_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      kind == SK_XTAL && !opt |-> range == RG_WIDE)
      else $error("programmed option fuse not wide mode");

   fuse_default_a: assert property (@(posedge mclk_i)
      $rose(rst_n_i) |-> fuse_reg == `CSSC_FUSE_RST)
      else $error("fuse image not delivered value");

   ext_clock_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      sel == `CSSC_SEL_EXTCLK |-> kind == SK_EXTCLK && src_tgt == `CSSC_CK_6)
      else $error("external clock decode wrong");

endmodule

// ### test/cssc_osc_model.sv
// Model of the selected clock source and the watchdog oscillator.
// Assumes the bench sets each tick period in system cycles, 0 stops it.
`timescale 1ns/1ps

module cssc_osc_model
(
   input wire logic mclk_i,
   input wire logic [3:0] src_div_i,
   input wire logic [3:0] wdt_div_i,
   output logic src_tick_o,
   output logic wdt_tick_o
);
   logic [3:0] src_cnt_reg;
   logic [3:0] wdt_cnt_reg;

   // Acts as a ceramic resonator, so range 101 is a legal setting
   always_ff @(posedge mclk_i)
   begin
      src_tick_o <= src_div_i != 4'h0 && src_cnt_reg >= src_div_i - 4'h1;
      src_cnt_reg <= (src_div_i == 4'h0 || src_cnt_reg >= src_div_i - 4'h1) ? 4'h0 : src_cnt_reg + 4'h1;
      wdt_tick_o <= wdt_div_i != 4'h0 && wdt_cnt_reg >= wdt_div_i - 4'h1;
      wdt_cnt_reg <= (wdt_div_i == 4'h0 || wdt_cnt_reg >= wdt_div_i - 4'h1) ? 4'h0 : wdt_cnt_reg + 4'h1;
   end
endmodule

// ### test/testbench.sv
// Self-checking bench for the clock source and start-up control block.
// Assumes a single 50 MHz clock and the oscillator model as tick source.
`timescale 1ns/1ps
`include "cssc_defs.svh"

module testbench
   import cssc_pkg::*;
;
   localparam int S16 = 10;
   localparam int S32 = 12;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic wake_i = 1'b0;
   logic hsel_i = 1'b0;
   logic [31:0] haddr_i = 32'h0;
   logic [1:0] htrans_i = 2'h0;
   logic hwrite_i = 1'b0;
   logic [2:0] hsize_i = 3'h2;
   logic [31:0] hwdata_i = 32'h0;
   logic [3:0] src_div = 4'h0;
   logic [3:0] wdt_div = 4'h0;
   logic hready, hresp, src_tick, wdt_tick, core_en, flash_en, io_en, asy_en, adc_en, async_det;
   logic [31:0] hrdata;
   logic [2:0] kind;
   logic [1:0] range;
   logic [31:0] rd;
   int error_cnt = 0;
   int n_compared = 0;
   int src_cnt = 0;
   int wdt_cnt = 0;
   logic [3:0] sels [5] = '{4'hA, 4'hB, 4'h9, 4'h5, 4'h1};

   always #10 mclk_i = ~mclk_i;

   // Tick tallies sampled on the same edges the design sees
   always @(posedge mclk_i)
   begin
      src_cnt <= src_cnt + int'(src_tick);
      wdt_cnt <= wdt_cnt + int'(wdt_tick);
   end

   cssc_osc_model u_cssc_osc_model (.mclk_i(mclk_i), .src_div_i(src_div), .wdt_div_i(wdt_div),
      .src_tick_o(src_tick), .wdt_tick_o(wdt_tick));

   cssc_top #(.WDT_SHORT(8), .WDT_LONG(16), .SRC_16K(S16), .SRC_32K(S32)) u_cssc_top (.mclk_i(mclk_i),
      .rst_n_i(rst_n_i), .src_tick_i(src_tick), .wdt_tick_i(wdt_tick), .wake_i(wake_i), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .core_clk_en_o(core_en),
      .flash_clk_en_o(flash_en), .io_clk_en_o(io_en), .asy_clk_en_o(asy_en), .adc_clk_en_o(adc_en),
      .async_detect_o(async_det), .src_kind_o(kind), .osc_range_o(range));

   task automatic report_and_stop();
      if (error_cnt == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [3:0] ofs, input logic [31:0] wd);
      hsel_i <= 1'b1;
      haddr_i <= {28'h0, ofs};
      htrans_i <= 2'h2;
      hwrite_i <= wr;
      hsize_i <= 3'h2;
      do @(posedge mclk_i); while (hready !== 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      do @(posedge mclk_i); while (hready !== 1'b1);
      rd = hrdata;
      check(hresp, 1'b0);
   endtask

   function automatic int start_cnt(input logic [3:0] s, input logic [1:0] u);
      if (s >= `CSSC_SEL_XTAL_MIN)
         return !s[0] ? (u[1] ? `CSSC_CK_1K : `CSSC_CK_258) : (u == 2'h0 ? `CSSC_CK_1K : S16);
      if (s == `CSSC_SEL_LFXTAL)
         return u[1] ? S32 : `CSSC_CK_1K;
      if (s >= `CSSC_SEL_ERC_MIN)
         return u == 2'h3 ? `CSSC_CK_6 : `CSSC_CK_18;
      return `CSSC_CK_6;
   endfunction

   function automatic logic [2:0] kind_of(input logic [3:0] s);
      if (s >= `CSSC_SEL_XTAL_MIN)
         return SK_XTAL;
      if (s == `CSSC_SEL_LFXTAL)
         return SK_LFXTAL;
      if (s >= `CSSC_SEL_ERC_MIN)
         return SK_ERC;
      return s == `CSSC_SEL_EXTCLK ? SK_EXTCLK : SK_IRC;
   endfunction

   // Counts selected-source ticks until the core clock comes back
   task automatic measure(input int c0, input int exp);
      int t;
      t = 0;
      while (core_en !== 1'b1 && t < 5000)
      begin
         @(posedge mclk_i);
         #1;
         t++;
      end
      check(src_cnt - c0, exp);
      check({core_en, flash_en, io_en, asy_en, adc_en}, 5'h1F);
   endtask

   task automatic nap(input logic [2:0] mode, input int exp);
      logic [4:0] en;
      src_div <= 4'h1 + 4'($urandom % 2);
      bus(1'b1, `CSSC_OFS_CTRL, {28'h0, 1'b1, mode});
      repeat (2) @(posedge mclk_i);
      #1;
      en = mode == 3'h0 ? 5'h07 : mode == 3'h1 ? 5'h03 : mode == 3'h2 ? 5'h02 : 5'h00;
      check({core_en, flash_en, io_en, asy_en, adc_en}, en);
      check(async_det, !en[2]);
      @(posedge mclk_i) wake_i <= 1'b1;
      @(posedge mclk_i) wake_i <= 1'b0;
      #1;
      measure(src_cnt, mode >= 3'h2 ? exp : 0);
   endtask

   task automatic wait_wdt(input int n);
      int t;
      int c0;
      t = 0;
      c0 = wdt_cnt;
      wdt_div <= 4'h3;
      while (wdt_cnt - c0 < n && t < 500)
      begin
         @(posedge mclk_i);
         #1;
         t++;
      end
      wdt_div <= 4'h0;
      bus(1'b0, `CSSC_OFS_STAT, 32'h0);
   endtask

   // Reset release, long watchdog extension, then the six-tick internal RC count
   task automatic boot();
      repeat (3) @(posedge mclk_i);
      check({core_en, flash_en, io_en, asy_en, adc_en, async_det}, 6'h01);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      #1;
      check(kind, SK_IRC);
      bus(1'b0, `CSSC_OFS_FUSE, 32'h0);
      check(rd, `CSSC_FUSE_RST);
      // Bench long extension is 16 ticks; the source count waits for all of them
      wait_wdt(15);
      check(rd[2:0], ST_RST_EXT);
      wait_wdt(1);
      check(rd[2:0], ST_START);
      check(core_en, 1'b0);
      src_div <= 4'h1;
      #1;
      measure(src_cnt, `CSSC_CK_6);
   endtask

   initial
   begin
      logic [3:0] s;
      logic [1:0] u;
      logic o;
      void'($urandom(20196));
      boot();
      bus(1'b1, 4'hC, 32'hFFFFFFFF);
      bus(1'b0, 4'hC, 32'h0);
      check(rd, 32'h0);
      for (int i = 0; i < 32; i++)
      begin
         s = 4'(i);
         o = i[4];
         bus(1'b1, `CSSC_OFS_FUSE, {25'h0, o, 2'h2, s});
         repeat (2) @(posedge mclk_i);
         #1;
         check(kind, kind_of(s));
         if (s >= `CSSC_SEL_XTAL_MIN)
            check(range, !o ? RG_WIDE : 2'(s[3:1] - 3'h5));
      end
      bus(1'b1, `CSSC_OFS_FUSE, `CSSC_FUSE_RST);
      for (int m = 0; m < 4; m++)
         nap(3'(m), `CSSC_CK_6);
      foreach (sels[k])
         for (int j = 0; j < 4; j++)
         begin
            bus(1'b1, `CSSC_OFS_FUSE, {25'h1, 2'(j), sels[k]});
            nap(3'h3, start_cnt(sels[k], 2'(j)));
         end
      repeat (10)
      begin
         s = 4'($urandom % 16);
         u = 2'($urandom % 4);
         bus(1'b1, `CSSC_OFS_FUSE, {25'h1, u, s});
         nap(3'h2 + 3'($urandom % 2), start_cnt(s, u));
      end
      // Mid-run reset must stop every domain and restore the delivered fuses
      src_div <= 4'h0;
      rst_n_i <= 1'b0;
      boot();
      report_and_stop();
   end

   initial
   begin
      repeat (90000) @(posedge mclk_i);
      error_cnt++;
      report_and_stop();
   end
endmodule
